// ---- core/host_interface_select_consts.svh ----
/*
 * Constants for the host interface select block: strap codes, slave
 * addresses and timing figures. Assumes inclusion by bare name.
 */
`ifndef HOST_INTERFACE_SELECT_CONSTS_SVH
`define HOST_INTERFACE_SELECT_CONSTS_SVH

// =====================================================================
// Strap decode: 3-bit code from the analog resistor sense front end
// =====================================================================
`define STRAP_R47K 3'h0
`define STRAP_R56K 3'h1
`define STRAP_R68K 3'h2
`define STRAP_R82K 3'h3
`define STRAP_R100K 3'h4
`define STRAP_R120K 3'h5
`define STRAP_R150K 3'h6
`define STRAP_VDD 3'h7

// =====================================================================
// Slave addresses
// =====================================================================
`define SLAVE_ADDR_82K 7'h2C
`define SLAVE_ADDR_100K 7'h2B
`define SLAVE_ADDR_120K 7'h2A
`define SLAVE_ADDR_150K 7'h29
`define SLAVE_ADDR_VDD 7'h28
`define SLAVE_ADDR_NONE 7'h00

// =====================================================================
// Timing
// =====================================================================
`define CLK_FREQ_KHZ 100000
`define QUIET_TIME_MS 15
`define QUIET_CYCLES (`QUIET_TIME_MS * `CLK_FREQ_KHZ)
`define WAKE_MIN_US 10
`define WAKE_MAX_US 20
`define WAKE_MIN_LINK_CYCLES 667
`define WAKE_MAX_LINK_CYCLES 1333
`define WAKE_COUNT_WIDTH 11
`define QUIET_COUNT_WIDTH 21
`define WAKE_COUNT_ZERO 11'h000
`define WAKE_COUNT_ONE 11'h001
`define QUIET_COUNT_ZERO 21'h000000
`define QUIET_COUNT_ONE 21'h000001

`endif

// ---- core/host_interface_select_pkg.sv ----
/*
 * Types for the host interface select block.
 * Assumes the constants header is compiled alongside.
 */
package host_interface_select_pkg;
    // Transport choice, Gray-ordered
    typedef enum logic [1:0] {
        proto_spi4_type_val = 2'h0,
        proto_spi3_type_val = 2'h1,
        proto_link_type_val = 2'h3,
        proto_smbus_type_val = 2'h2
    } protocol_type;

    // Power-up sequencer states, Gray path
    typedef enum logic [1:0] {
        st_capture = 2'h0,
        st_quiet = 2'h1,
        st_ready = 2'h3
    } startup_type;
endpackage : host_interface_select_pkg

// ---- core/host_interface_select.sv ----
/*
 * Host interface select: latches the interface strap at reset release,
 * decodes transport and slave address, gates host traffic during the
 * power-up quiet time and checks the SPI wake interval on the link clock.
 * Assumes an analog front end turns the strap resistor into a 3-bit code,
 * and the protocol engines sit downstream of these outputs.
 */
// What this block does
// - Pick host transport from the strap resistor value on the interface pin.
// - 47k or less four-wire SPI, 56k three-wire SPI, 68k two-wire link.
// - SMBus addresses 82k 2C, 100k 2B, 120k 2A, 150k 29, supply 28.
// - Register behaviour identical for every transport; only transport differs.
// - Ignore all host traffic for up to 15 ms after power-up; host_read still follows valid direction bits and wake_violation still flags early SPI clocks.
// - Ignore SPI chip select when SMBus or two-wire link chosen.
// - Address byte is 7-bit slave address then direction bit, 1 read.
`include "host_interface_select_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module host_interface_select
    import host_interface_select_pkg::*;
#(
    parameter int quiet_cycles = `QUIET_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic link_clk,
    input wire logic [2:0] interface_strap_pin,
    input wire logic spi_cs_n,
    input wire logic spi_clk,
    input wire logic [7:0] address_byte,
    input wire logic address_byte_valid,
    output logic [1:0] protocol,
    output logic [6:0] slave_address,
    output logic host_enable,
    output logic spi_cs_n_gated,
    output logic address_match,
    output logic host_read,
    output logic wake_violation
);

    // =================================================================
    // Strap sampling
    // =================================================================
    logic [2:0] strap_meta;
    logic [2:0] strap_sync;

    // Pin is asynchronous: two flops before decode
    always_ff @(posedge clk) begin
        strap_meta <= interface_strap_pin;
        strap_sync <= strap_meta;
    end

    // =================================================================
    // Decode
    // =================================================================
    wire logic is_spi4 = (strap_sync == `STRAP_R47K);
    wire logic is_spi3 = (strap_sync == `STRAP_R56K);
    wire logic is_link = (strap_sync == `STRAP_R68K);
    wire protocol_type next_protocol = is_spi4 ? proto_spi4_type_val :
                                       is_spi3 ? proto_spi3_type_val :
                                       is_link ? proto_link_type_val :
                                       proto_smbus_type_val;
    wire logic [6:0] next_slave_address =
        (strap_sync == `STRAP_R82K) ? `SLAVE_ADDR_82K :
        (strap_sync == `STRAP_R100K) ? `SLAVE_ADDR_100K :
        (strap_sync == `STRAP_R120K) ? `SLAVE_ADDR_120K :
        (strap_sync == `STRAP_R150K) ? `SLAVE_ADDR_150K :
        (strap_sync == `STRAP_VDD) ? `SLAVE_ADDR_VDD :
        `SLAVE_ADDR_NONE;

    // =================================================================
    // Startup sequencer
    // =================================================================
    startup_type state;
    startup_type next_state;
    logic [`QUIET_COUNT_WIDTH-1:0] quiet_count;
    logic [1:0] settle;
    wire logic quiet_done = (quiet_count == `QUIET_COUNT_ZERO);
    wire logic settled = settle[1];

    // Wait two cycles so the synchroniser holds post-reset strap value
    always_comb begin
        next_state = state;
        case (state)
            st_capture: next_state = settled ? st_quiet : st_capture;
            st_quiet: next_state = quiet_done ? st_ready : st_quiet;
            st_ready: next_state = st_ready;
            default: next_state = st_capture;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= st_capture;
            settle <= 2'h0;
        end else begin
            state <= next_state;
            settle <= {settle[0], 1'b1};
        end
    end

    // Quiet counter loads at capture, then runs down
    always_ff @(posedge clk) begin
        if (reset) begin
            quiet_count <= `QUIET_COUNT_ZERO;
        end else if (state == st_capture) begin
            quiet_count <= quiet_cycles[`QUIET_COUNT_WIDTH-1:0];
        end else if (!quiet_done) begin
            quiet_count <= quiet_count - `QUIET_COUNT_ONE;
        end
    end

    // Latch once; nothing but reset reopens it
    always_ff @(posedge clk) begin
        if (reset) begin
            protocol <= proto_spi4_type_val;
            slave_address <= `SLAVE_ADDR_NONE;
        end else if (state == st_capture && settled) begin
            protocol <= next_protocol;
            slave_address <= next_slave_address;
        end
    end

    // =================================================================
    // Chip select into system domain
    // =================================================================
    logic cs_meta;
    logic cs_sync;
    always_ff @(posedge clk) begin
        cs_meta <= !spi_cs_n;
        cs_sync <= cs_meta;
    end

    // =================================================================
    // Host gating; same gate for all transports so behaviour matches
    // =================================================================
    wire logic ready = (state == st_ready);
    wire logic spi_mode = (protocol == proto_spi4_type_val) ||
                          (protocol == proto_spi3_type_val);
    wire logic smbus_mode = (protocol == proto_smbus_type_val);
    wire logic byte_hit = (address_byte[7:1] == slave_address);

    always_ff @(posedge clk) begin
        if (reset) begin
            host_enable <= 1'b0;
            spi_cs_n_gated <= 1'b1;
            address_match <= 1'b0;
            host_read <= 1'b0;
        end else begin
            host_enable <= ready;
            spi_cs_n_gated <= !(host_enable && spi_mode && cs_sync);
            address_match <= host_enable && smbus_mode && address_byte_valid && byte_hit;
            host_read <= address_byte_valid ? address_byte[0] : host_read;
        end
    end

    // =================================================================
    // Link domain: wake interval check (15 ns link clock)
    // =================================================================
    logic link_rst_meta;
    logic link_rst;
    logic lcs_meta;
    logic lcs_sync;
    logic lsclk_meta;
    logic lsclk_sync;
    logic lsclk_prev;
    logic [`WAKE_COUNT_WIDTH-1:0] wake_count;
    logic link_violation;
    wire logic sclk_edge = lsclk_sync && !lsclk_prev;
    wire logic early_clock = lcs_sync && sclk_edge &&
                             (wake_count < `WAKE_MIN_LINK_CYCLES);

    // Reset and pins synchronised into the link domain
    always_ff @(posedge link_clk) begin
        link_rst_meta <= reset;
        link_rst <= link_rst_meta;
        lcs_meta <= !spi_cs_n;
        lcs_sync <= lcs_meta;
        lsclk_meta <= spi_clk;
        lsclk_sync <= lsclk_meta;
        lsclk_prev <= lsclk_sync;
    end

    // Counts time since select; saturates, host is obliged to wait
    always_ff @(posedge link_clk) begin
        if (link_rst || !lcs_sync) begin
            wake_count <= `WAKE_COUNT_ZERO;
            link_violation <= 1'b0;
        end else begin
            if (wake_count < `WAKE_MAX_LINK_CYCLES) begin
                wake_count <= wake_count + `WAKE_COUNT_ONE;
            end
            if (early_clock) begin
                link_violation <= 1'b1;
            end
        end
    end

    // Violation level back to system domain
    logic viol_meta;
    logic viol_sync;
    always_ff @(posedge clk) begin
        viol_meta <= link_violation;
        viol_sync <= viol_meta;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wake_violation <= 1'b0;
        end else begin
            wake_violation <= viol_sync && spi_mode;
        end
    end

endmodule : host_interface_select

`default_nettype wire

// ---- testbench/host_interface_select_properties.sv ----
/* Port checker for host_interface_select.
   Assumes it is bound onto every instance of that module. */
`timescale 1ns/1ns
`default_nettype none
module host_interface_select_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] address_byte,
    input wire logic address_byte_valid,
    input wire logic [1:0] protocol,
    input wire logic [6:0] slave_address,
    input wire logic host_enable,
    input wire logic spi_cs_n_gated,
    input wire logic address_match,
    input wire logic host_read
);
    // ==========================================================
    // Relations between the outputs and their causes
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire logic bus_mode = protocol == 2'h2;
    wire logic hit = address_byte[7:1] == slave_address;
    property p_none; !bus_mode |-> slave_address == 7'h00; endproperty
    a_none: assert property (p_none) else $error("address outside bus mode");
    property p_range; bus_mode |-> slave_address inside {[7'h28:7'h2C]}; endproperty
    a_range: assert property (p_range) else $error("address out of set");
    property p_hold; host_enable |-> $stable(protocol) && $stable(slave_address); endproperty
    a_hold: assert property (p_hold) else $error("latched choice moved");
    property p_cause; address_match |-> $past(address_byte_valid && host_enable && hit); endproperty
    a_cause: assert property (p_cause) else $error("match without cause");
    property p_hit; address_byte_valid && host_enable && bus_mode && hit |=> address_match; endproperty
    a_hit: assert property (p_hit) else $error("missed match");
    property p_rw; address_byte_valid |=> host_read == $past(address_byte[0]); endproperty
    a_rw: assert property (p_rw) else $error("direction bit wrong");
    property p_cs; protocol[1] |-> spi_cs_n_gated; endproperty
    a_cs: assert property (p_cs) else $error("select passed in wrong mode");
    property p_quiet; !host_enable |-> spi_cs_n_gated && !address_match; endproperty
    a_quiet: assert property (p_quiet) else $error("traffic in quiet time");
    property p_on; host_enable |=> host_enable; endproperty
    a_on: assert property (p_on) else $error("enable dropped");
    c_match: cover property (address_match && host_read);
    c_spi: cover property (!spi_cs_n_gated);
    c_on: cover property ($rose(host_enable));
endmodule : host_interface_select_properties
bind host_interface_select host_interface_select_properties chk (.clk(clk), .reset(reset),
    .address_byte(address_byte), .address_byte_valid(address_byte_valid), .protocol(protocol),
    .slave_address(slave_address), .host_enable(host_enable), .spi_cs_n_gated(spi_cs_n_gated),
    .address_match(address_match), .host_read(host_read));
`default_nettype wire

// ---- testbench/host_spi_model.sv ----
/* Host side SPI select and clock model.
   Assumes go is pulsed only while no frame is running. */
`timescale 1ns/1ns
`default_nettype none
module host_spi_model (
    input wire logic link_clk,
    input wire logic go,
    input wire logic [10:0] wake,
    output logic spi_cs_n,
    output logic spi_clk,
    output logic busy
);
    // ==========================================================
    // Clock stands still outside frames
    initial begin
        spi_cs_n = 1'b1;
        spi_clk = 1'b0;
        busy = 1'b0;
    end
    // Select, idle for the wake span, four clocks, release
    always @(posedge go) begin
        busy = 1'b1;
        @(posedge link_clk) #2 spi_cs_n = 1'b0;
        repeat (wake) @(posedge link_clk);
        repeat (4) begin
            @(posedge link_clk) #2 spi_clk = 1'b1;
            @(posedge link_clk) #2 spi_clk = 1'b0;
        end
        @(posedge link_clk) #2 spi_cs_n = 1'b1;
        busy = 1'b0;
    end
endmodule : host_spi_model
`default_nettype wire

// ---- testbench/tb.sv ----
/* Self-checking bench for host_interface_select.
   Assumes the package and constants header are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import host_interface_select_pkg::*;
    logic clk, reset, link_clk, spi_cs_n, spi_clk, address_byte_valid, go, busy, m, lo, v;
    logic [2:0] interface_strap_pin;
    logic [7:0] address_byte;
    logic [10:0] wake;
    logic [1:0] protocol;
    logic [6:0] slave_address;
    logic host_enable, spi_cs_n_gated, address_match, host_read, wake_violation;
    int failures, check_count;
    logic [6:0] adr [8] = '{7'h00, 7'h00, 7'h00, 7'h2C, 7'h2B, 7'h2A, 7'h29, 7'h28};
    protocol_type pro [8] = '{proto_spi4_type_val, proto_spi3_type_val, proto_link_type_val,
        proto_smbus_type_val, proto_smbus_type_val, proto_smbus_type_val,
        proto_smbus_type_val, proto_smbus_type_val};
    host_interface_select #(.quiet_cycles(20)) uut (.clk(clk), .reset(reset),
        .link_clk(link_clk), .interface_strap_pin(interface_strap_pin), .spi_cs_n(spi_cs_n),
        .spi_clk(spi_clk), .address_byte(address_byte), .address_byte_valid(address_byte_valid),
        .protocol(protocol), .slave_address(slave_address), .host_enable(host_enable),
        .spi_cs_n_gated(spi_cs_n_gated), .address_match(address_match), .host_read(host_read),
        .wake_violation(wake_violation));
    host_spi_model host (.link_clk(link_clk), .go(go), .wake(wake), .spi_cs_n(spi_cs_n),
        .spi_clk(spi_clk), .busy(busy));
    // ==========================================================
    // Clocks; link clock offset by 3 ns, its rising edge still meets a clk rising edge every 30 ns
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        link_clk = 0;
        #3;
        forever begin
            #7 link_clk = 1;
            #8 link_clk = 0;
        end
    end
    task check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // One valid byte; match is read just after the edge that takes it
    task send(input logic [7:0] b, output logic hit);
        @(posedge clk) #1 address_byte = b;
        address_byte_valid = 1;
        @(posedge clk) #1 address_byte_valid = 0;
        hit = address_match;
    endtask : send
    // Reset with a strap, probe the quiet time, wait for enable
    task start(input logic [2:0] code);
        int n;
        @(posedge clk) #1 reset = 1;
        interface_strap_pin = code;
        repeat (8) @(posedge clk);
        #1 reset = 0;
        send({adr[code], 1'b0}, m);
        check(m, 0);
        for (n = 2; host_enable !== 1'b1 && n < 100; n++) @(posedge clk) #1;
        check(n > 20 && n < 100, 1);
    endtask : start
    // Frame from the host model; gathers select pass and wake flag
    task frame(input logic [10:0] w);
        int n;
        lo = 0;
        v = 0;
        wake = w;
        check(spi_cs_n_gated, 1);
        @(posedge clk) #1 go = 1;
        @(posedge clk) #1 go = 0;
        for (n = 0; n < 3000 && (busy || n < 20); n++) begin
            @(posedge clk) #1 lo = lo | ~spi_cs_n_gated;
            v = v | wake_violation;
        end
        check(busy, 0);
        repeat (10) @(posedge clk);
    endtask : frame
    task report_and_stop;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // Every strap code in turn; the bench tracks its expectations
    initial begin
        reset = 1;
        go = 0;
        wake = 0;
        interface_strap_pin = 0;
        address_byte = 0;
        address_byte_valid = 0;
        for (int c = 0; c < 8; c++) begin
            start(c[2:0]);
            check(protocol, pro[c]);
            check(slave_address, adr[c]);
            if (c >= 3) begin
                send({adr[c], 1'b1}, m);
                check({m, host_read}, 2'h3);
                send({adr[c] + 7'h01, 1'b0}, m);
                check({m, host_read}, 2'h0);
            end
            frame(11'd700);
            check({lo, v}, {c < 2, 1'b0});
            if (c < 2) begin
                frame(11'd100);
                check(v, 1);
            end
        end
        report_and_stop();
    end
    // Watchdog at about three times the expected run length
    initial begin
        #300000;
        failures++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
